// file: rtl/burner_pkg.sv
// shared constants, timings, encodings and register map of the burner sequencer
package burner_pkg;

  // clock and time base
  localparam int CLK_HZ   = 125_000_000;
  localparam int TICK_MS  = 100;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int BOOT_CYC = 5;

  typedef logic [9:0] ticks_t;

  // phase times in ms
  localparam int AIR_TIMEOUT_MS = 60000;
  localparam int PREPURGE_MS    = 24000;
  localparam int STRAY_MS       = 5000;
  localparam int PREIGN_MS      = 3000;
  localparam int POSTIGN_V1_MS  = 2500;
  localparam int SAFETY_V1_MS   = 3000;
  localparam int STAGE2_V1_MS   = 12500;
  localparam int POSTIGN_V2_MS  = 4000;
  localparam int SAFETY_V2_MS   = 5000;
  localparam int STAGE2_V2_MS   = 14000;
  localparam int QUICK_FAN_MS   = 2500;
  localparam int QUICK_LOCK_MS  = 10000;
  localparam int BTN_HOLD_MS    = 3000;
  localparam int LOCK_STEADY_MS = 10000;
  localparam int LOCK_PAUSE_MS  = 600;
  localparam int LOCK_CODE_MS   = 1200;
  localparam int PHASE_FRAME_MS = 2000;

  // the same times in ticks; longest times round down, least times round up
  localparam ticks_t AIR_TIMEOUT_TK = ticks_t'(AIR_TIMEOUT_MS / TICK_MS);
  localparam ticks_t PREPURGE_TK    = ticks_t'((PREPURGE_MS + TICK_MS - 1) / TICK_MS);
  localparam ticks_t STRAY_TK       = ticks_t'((STRAY_MS + TICK_MS - 1) / TICK_MS);
  localparam ticks_t PREIGN_TK      = ticks_t'((PREIGN_MS + TICK_MS - 1) / TICK_MS);
  localparam ticks_t POSTIGN_V1_TK  = ticks_t'(POSTIGN_V1_MS / TICK_MS);
  localparam ticks_t SAFETY_V1_TK   = ticks_t'(SAFETY_V1_MS / TICK_MS);
  localparam ticks_t STAGE2_V1_TK   = ticks_t'((STAGE2_V1_MS + TICK_MS - 1) / TICK_MS);
  localparam ticks_t POSTIGN_V2_TK  = ticks_t'(POSTIGN_V2_MS / TICK_MS);
  localparam ticks_t SAFETY_V2_TK   = ticks_t'(SAFETY_V2_MS / TICK_MS);
  localparam ticks_t STAGE2_V2_TK   = ticks_t'((STAGE2_V2_MS + TICK_MS - 1) / TICK_MS);
  localparam ticks_t QUICK_FAN_TK   = ticks_t'(QUICK_FAN_MS / TICK_MS);
  localparam ticks_t QUICK_LOCK_TK  = ticks_t'((QUICK_LOCK_MS + TICK_MS - 1) / TICK_MS);
  localparam ticks_t BTN_HOLD_TK    = ticks_t'(BTN_HOLD_MS / TICK_MS);
  localparam ticks_t LOCK_STEADY_TK = ticks_t'(LOCK_STEADY_MS / TICK_MS);
  localparam ticks_t LOCK_PAUSE_TK  = ticks_t'(LOCK_PAUSE_MS / TICK_MS);
  localparam ticks_t LOCK_CODE_TK   = ticks_t'(LOCK_CODE_MS / TICK_MS);
  localparam ticks_t PHASE_FRAME_TK = ticks_t'(PHASE_FRAME_MS / TICK_MS);

  // sequencer states, gray along the start-up path
  typedef enum logic [3:0] {
    ST_IDLE       = 4'h0,
    ST_AIR_WAIT   = 4'h1,
    ST_PREPURGE   = 4'h3,
    ST_STRAY      = 4'h2,
    ST_PREIGN     = 4'h6,
    ST_SAFETY     = 4'h7,
    ST_POSTIGN    = 4'h5,
    ST_STAGE2     = 4'h4,
    ST_RUN        = 4'hC,
    ST_LOCKOUT    = 4'hD,
    ST_QUICK_FAN  = 4'hF,
    ST_QUICK_LOCK = 4'hE,
    ST_UV_WAIT    = 4'hA
  } state_e;

  // lockout causes
  typedef enum logic [2:0] {
    CAUSE_NONE        = 3'h0,
    CAUSE_SAFETY      = 3'h1,
    CAUSE_STRAY       = 3'h2,
    CAUSE_AIR_CLOSED  = 3'h3,
    CAUSE_AIR_TIMEOUT = 3'h4,
    CAUSE_AIR_OPENED  = 3'h5,
    CAUSE_FLAME_LOSS  = 3'h6
  } cause_e;

  // phase flash patterns, one bit per tick, bit 0 first
  localparam logic [19:0] PAT_IDLE     = 20'h00000;
  localparam logic [19:0] PAT_AIR_WAIT = 20'h00005;
  localparam logic [19:0] PAT_PREPURGE = 20'h00015;
  localparam logic [19:0] PAT_PREIGN   = 20'h00055;
  localparam logic [19:0] PAT_SAFETY   = 20'h00057;
  localparam logic [19:0] PAT_STAGE2   = 20'h00157;
  localparam logic [19:0] PAT_RUN      = 20'h00007;
  localparam logic [19:0] PAT_UV_WAIT  = 20'h00077;

  // lockout cause flash codes, one bit per tick
  localparam logic [11:0] CODE_SAFETY      = 12'h001;
  localparam logic [11:0] CODE_STRAY       = 12'h005;
  localparam logic [11:0] CODE_AIR_CLOSED  = 12'h015;
  localparam logic [11:0] CODE_AIR_TIMEOUT = 12'h007;
  localparam logic [11:0] CODE_AIR_OPENED  = 12'h017;
  localparam logic [11:0] CODE_FLAME_LOSS  = 12'h077;

  // register map
  localparam logic [3:0] REG_CTRL         = 4'h0;
  localparam logic [3:0] REG_STATUS       = 4'h1;
  localparam int         CTRL_RUN_EN_BIT  = 0;
  localparam logic [7:0] CTRL_RESET       = 8'h01;
  localparam int         STATUS_CAUSE_LSB = 4;
  localparam int         STATUS_LOCK_BIT  = 7;

endpackage

// file: rtl/burner_sequencer.sv
// two-stage burner safety sequencer with supervision, lockout store and led information display
//
// Contract
// - after start, wait for air switch; lockout air time-out after 60 s
// - pre-purge 24 s and pre-ignition 3 s in both variants
// - variant parameter picks post-ignition, safety time and second-stage delay
// - flame seen in 5 s window after pre-purge gives stray-light lockout
// - no flame at end of safety time gives safety-time lockout
// - air switch opening during start-up or running gives immediate lockout
// - flame loss while running locks out directly, no restart attempt
// - lockout cause written to nonvolatile store, shown again after power loss
// - outside lockout the led shows a flash pattern per phase, stray window as pre-purge, post-ignition as safety, quick fan dark
// - in lockout the led starts lit and the display cycle repeats until reset
// - lockout cycle is 10 s steady, 0.6 s dark, 1.2 s cause code
// - button press in lockout clears it and starts a new start-up
// - external button is ORed with the built-in one
// - button held over 3 s then released during sequence makes a shutdown
// - undervoltage during sequence makes safety shutdown into a waiting state
// - supply-good restarts from waiting; start only allowed with supply-good
// - air closed at start: brief fan, quick lockout, 10 s, one retry
module burner_sequencer #(
  parameter int TICK_CYC = burner_pkg::TICK_CYC,
  parameter bit VARIANT  = 1'b0
) (
  // clock and reset
  input  wire logic       SYS_CLK_I,
  input  wire logic       RST_N_I,
  // demand and field contacts
  input  wire logic       START_REQ_I,
  input  wire logic       AIR_PROVING_CONTACT_I,
  input  wire logic       FLAME_I,
  input  wire logic       BUTTON_INT_I,
  input  wire logic       BUTTON_EXT_I,
  // supply monitor
  input  wire logic       SUPPLY_LOW_I,
  input  wire logic       SUPPLY_GOOD_I,
  // nonvolatile cause store
  input  wire logic [2:0] NV_CAUSE_I,
  output logic            NV_WR_O,
  output logic      [2:0] NV_CAUSE_O,
  // register port
  input  wire logic [3:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  // actuators and indicators
  output logic            FAN_MOTOR_O,
  output logic            IGNITION_O,
  output logic            FIRST_STAGE_VALVE_O,
  output logic            SECOND_STAGE_VALVE_O,
  output logic            ALARM_O,
  output logic            LED_O
);

  typedef burner_pkg::ticks_t ticks_t;

  // phase flash pattern bit per state and frame tick
  function automatic logic phase_pat(input burner_pkg::state_e s, input logic [4:0] i);
    logic [19:0] p;
    p = burner_pkg::PAT_IDLE;
    case (s)
      burner_pkg::ST_AIR_WAIT:  p = burner_pkg::PAT_AIR_WAIT;
      burner_pkg::ST_PREPURGE,
      burner_pkg::ST_STRAY:     p = burner_pkg::PAT_PREPURGE;
      burner_pkg::ST_PREIGN:    p = burner_pkg::PAT_PREIGN;
      burner_pkg::ST_SAFETY,
      burner_pkg::ST_POSTIGN:   p = burner_pkg::PAT_SAFETY;
      burner_pkg::ST_STAGE2:    p = burner_pkg::PAT_STAGE2;
      burner_pkg::ST_RUN:       p = burner_pkg::PAT_RUN;
      burner_pkg::ST_UV_WAIT:   p = burner_pkg::PAT_UV_WAIT;
      default:                  p = burner_pkg::PAT_IDLE;
    endcase
    return p[i];
  endfunction

  // cause flash code
  function automatic logic [11:0] cause_code(input burner_pkg::cause_e c);
    logic [11:0] k;
    k = 12'h000;
    case (c)
      burner_pkg::CAUSE_SAFETY:      k = burner_pkg::CODE_SAFETY;
      burner_pkg::CAUSE_STRAY:       k = burner_pkg::CODE_STRAY;
      burner_pkg::CAUSE_AIR_CLOSED:  k = burner_pkg::CODE_AIR_CLOSED;
      burner_pkg::CAUSE_AIR_TIMEOUT: k = burner_pkg::CODE_AIR_TIMEOUT;
      burner_pkg::CAUSE_AIR_OPENED:  k = burner_pkg::CODE_AIR_OPENED;
      burner_pkg::CAUSE_FLAME_LOSS:  k = burner_pkg::CODE_FLAME_LOSS;
      default:                       k = 12'h000;
    endcase
    return k;
  endfunction

  // synchronised field inputs
  logic [9:0] sync_w;
  logic       demand_w;
  logic       air_w;
  logic       flame_w;
  logic       btn_w;
  logic       low_w;
  logic       good_w;
  logic [2:0] nv_in_w;

  pin_sync #(.W(10)) u_sync (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RST_N_I),
    .d_i     ({NV_CAUSE_I, SUPPLY_GOOD_I, SUPPLY_LOW_I, BUTTON_EXT_I, BUTTON_INT_I,
               FLAME_I, AIR_PROVING_CONTACT_I, START_REQ_I}),
    .q_o     (sync_w)
  );

  assign demand_w = sync_w[0];
  assign air_w    = sync_w[1];
  assign flame_w  = sync_w[2];
  assign btn_w    = sync_w[3] | sync_w[4];
  assign low_w    = sync_w[5];
  assign good_w   = sync_w[6];
  assign nv_in_w  = sync_w[9:7];

  // state and bookkeeping
  burner_pkg::state_e state_q, state_d;
  burner_pkg::cause_e cause_q, cause_d;
  logic        retry_q, retry_d;
  logic [2:0]  boot_q;
  logic        boot_done_w;
  logic        boot_last_w;
  logic [23:0] pre_q;
  logic        tick_w;
  logic        chg_w;
  ticks_t      tmr_q;
  ticks_t      len_w;
  logic        done_w;

  assign boot_done_w = (boot_q == 3'(burner_pkg::BOOT_CYC));
  assign boot_last_w = (boot_q == 3'(burner_pkg::BOOT_CYC - 1));
  assign chg_w       = (state_d != state_q);
  assign tick_w      = (pre_q == 24'(TICK_CYC - 1));
  assign done_w      = tick_w && (tmr_q == len_w - ticks_t'(1));

  // phase length; only the variant phases depend on the parameter
  assign len_w =
    (state_q == burner_pkg::ST_AIR_WAIT)   ? burner_pkg::AIR_TIMEOUT_TK :
    (state_q == burner_pkg::ST_PREPURGE)   ? burner_pkg::PREPURGE_TK :
    (state_q == burner_pkg::ST_STRAY)      ? burner_pkg::STRAY_TK :
    (state_q == burner_pkg::ST_PREIGN)     ? burner_pkg::PREIGN_TK :
    (state_q == burner_pkg::ST_SAFETY)     ?
      (VARIANT ? burner_pkg::SAFETY_V2_TK : burner_pkg::SAFETY_V1_TK) :
    (state_q == burner_pkg::ST_POSTIGN)    ?
      (VARIANT ? burner_pkg::POSTIGN_V2_TK : burner_pkg::POSTIGN_V1_TK) :
    (state_q == burner_pkg::ST_STAGE2)     ?
      (VARIANT ? burner_pkg::STAGE2_V2_TK : burner_pkg::STAGE2_V1_TK) :
    (state_q == burner_pkg::ST_QUICK_FAN)  ? burner_pkg::QUICK_FAN_TK :
    (state_q == burner_pkg::ST_QUICK_LOCK) ? burner_pkg::QUICK_LOCK_TK : ticks_t'(0);

  // button edges and long-hold tracking
  logic   btn_prev_q;
  logic   hold_arm_q;
  ticks_t hold_q;
  logic   press_w;
  logic   release_w;
  logic   long_rel_w;

  assign press_w    = btn_w & ~btn_prev_q;
  assign release_w  = ~btn_w & btn_prev_q;
  assign long_rel_w = release_w & hold_arm_q & (hold_q > burner_pkg::BTN_HOLD_TK);

  // register port state
  logic [7:0] ctrl_q;
  logic       run_en_w;
  logic       in_seq_w;
  logic       air_sup_w;
  logic       start_ok_w;

  assign run_en_w   = ctrl_q[burner_pkg::CTRL_RUN_EN_BIT];
  assign start_ok_w = demand_w & run_en_w & good_w & ~low_w;
  assign in_seq_w   = (state_q inside {burner_pkg::ST_AIR_WAIT, burner_pkg::ST_PREPURGE,
                       burner_pkg::ST_STRAY, burner_pkg::ST_PREIGN, burner_pkg::ST_SAFETY,
                       burner_pkg::ST_POSTIGN, burner_pkg::ST_STAGE2, burner_pkg::ST_RUN});
  assign air_sup_w  = in_seq_w && (state_q != burner_pkg::ST_AIR_WAIT);

  // next state; later assignments override earlier ones, undervoltage last
  always_comb begin
    state_d = state_q;
    cause_d = cause_q;
    retry_d = retry_q;
    if (!boot_done_w) begin
      if (boot_last_w && (nv_in_w != 3'(burner_pkg::CAUSE_NONE))) begin
        state_d = burner_pkg::ST_LOCKOUT;
        cause_d = burner_pkg::cause_e'(nv_in_w);
      end
    end else begin
      unique case (state_q)
        burner_pkg::ST_IDLE: begin
          retry_d = 1'b0;
          if (start_ok_w) begin
            state_d = air_w ? burner_pkg::ST_QUICK_FAN : burner_pkg::ST_AIR_WAIT;
          end
        end
        burner_pkg::ST_QUICK_FAN: begin
          if (done_w && !air_w) begin
            state_d = burner_pkg::ST_AIR_WAIT;
          end else if (done_w && retry_q) begin
            state_d = burner_pkg::ST_LOCKOUT;
            cause_d = burner_pkg::CAUSE_AIR_CLOSED;
          end else if (done_w) begin
            state_d = burner_pkg::ST_QUICK_LOCK;
          end
        end
        burner_pkg::ST_QUICK_LOCK: begin
          if (done_w) begin
            state_d = burner_pkg::ST_QUICK_FAN;
            retry_d = 1'b1;
          end
        end
        burner_pkg::ST_AIR_WAIT: begin
          if (air_w) begin
            state_d = burner_pkg::ST_PREPURGE;
          end else if (done_w) begin
            state_d = burner_pkg::ST_LOCKOUT;
            cause_d = burner_pkg::CAUSE_AIR_TIMEOUT;
          end
        end
        burner_pkg::ST_PREPURGE: begin
          if (done_w) state_d = burner_pkg::ST_STRAY;
        end
        burner_pkg::ST_STRAY: begin
          if (flame_w) begin
            state_d = burner_pkg::ST_LOCKOUT;
            cause_d = burner_pkg::CAUSE_STRAY;
          end else if (done_w) begin
            state_d = burner_pkg::ST_PREIGN;
          end
        end
        burner_pkg::ST_PREIGN: begin
          if (done_w) state_d = burner_pkg::ST_SAFETY;
        end
        burner_pkg::ST_SAFETY: begin
          if (done_w && flame_w) begin
            state_d = burner_pkg::ST_POSTIGN;
          end else if (done_w) begin
            state_d = burner_pkg::ST_LOCKOUT;
            cause_d = burner_pkg::CAUSE_SAFETY;
          end
        end
        burner_pkg::ST_POSTIGN,
        burner_pkg::ST_STAGE2,
        burner_pkg::ST_RUN: begin
          if (!flame_w) begin
            state_d = burner_pkg::ST_LOCKOUT;
            cause_d = burner_pkg::CAUSE_FLAME_LOSS;
          end else if (done_w && (state_q == burner_pkg::ST_POSTIGN)) begin
            state_d = burner_pkg::ST_STAGE2;
          end else if (done_w && (state_q == burner_pkg::ST_STAGE2)) begin
            state_d = burner_pkg::ST_RUN;
          end
        end
        burner_pkg::ST_LOCKOUT: begin
          if (press_w) begin
            state_d = burner_pkg::ST_IDLE;
            cause_d = burner_pkg::CAUSE_NONE;
          end
        end
        burner_pkg::ST_UV_WAIT: begin
          if (good_w && !low_w) state_d = burner_pkg::ST_IDLE;
        end
        default: begin
          state_d = burner_pkg::ST_LOCKOUT; // illegal code fails safe
        end
      endcase
      // normal shutdown: demand gone, software disable, long button hold
      if (in_seq_w && (!demand_w || !run_en_w || long_rel_w)) begin
        state_d = burner_pkg::ST_IDLE;
      end
      if (air_sup_w && !air_w) begin
        state_d = burner_pkg::ST_LOCKOUT;
        cause_d = burner_pkg::CAUSE_AIR_OPENED;
      end
      if (in_seq_w && low_w) begin
        state_d = burner_pkg::ST_UV_WAIT;
        cause_d = cause_q;
      end
    end
  end

  // sequencer registers; prescaler restarts with each phase so phases are exact
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_q <= burner_pkg::ST_IDLE;
      cause_q <= burner_pkg::CAUSE_NONE;
      retry_q <= 1'b0;
      boot_q  <= 3'h0;
      pre_q   <= 24'h000000;
      tmr_q   <= '0;
    end else begin
      state_q <= state_d;
      cause_q <= cause_d;
      retry_q <= retry_d;
      boot_q  <= boot_done_w ? boot_q : boot_q + 3'h1;
      pre_q   <= (chg_w || tick_w) ? 24'h000000 : pre_q + 24'h000001;
      tmr_q   <= chg_w ? ticks_t'(0) : (tick_w ? tmr_q + ticks_t'(1) : tmr_q);
    end
  end

  // button hold: armed only by a press outside lockout, so a reset press cannot shut down
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      btn_prev_q <= 1'b0;
      hold_arm_q <= 1'b0;
      hold_q     <= '0;
    end else begin
      btn_prev_q <= btn_w;
      hold_arm_q <= (press_w && in_seq_w) || (hold_arm_q && btn_w && in_seq_w);
      if (press_w) begin
        hold_q <= '0;
      end else if (tick_w && btn_w && (hold_q <= burner_pkg::BTN_HOLD_TK)) begin
        hold_q <= hold_q + ticks_t'(1);
      end
    end
  end

  // led display counters
  logic [6:0]  lcnt_q;
  logic [4:0]  pidx_q;
  logic        lock_disp_w;
  logic [11:0] code_w;
  logic        led_lock_w;
  logic        led_d;
  logic [6:0]  steady_w;
  logic [6:0]  dark_end_w;
  logic [6:0]  cycle_w;

  assign steady_w    = 7'(burner_pkg::LOCK_STEADY_TK);
  assign dark_end_w  = 7'(burner_pkg::LOCK_STEADY_TK + burner_pkg::LOCK_PAUSE_TK);
  assign cycle_w     = 7'(burner_pkg::LOCK_STEADY_TK + burner_pkg::LOCK_PAUSE_TK + burner_pkg::LOCK_CODE_TK);
  assign lock_disp_w = (state_q == burner_pkg::ST_LOCKOUT) || (state_q == burner_pkg::ST_QUICK_LOCK);
  assign code_w      = cause_code((state_q == burner_pkg::ST_QUICK_LOCK) ?
                                  burner_pkg::CAUSE_AIR_CLOSED : cause_q);
  assign led_lock_w  = (lcnt_q < steady_w) ? 1'b1 :
                       (lcnt_q < dark_end_w) ? 1'b0 :
                       code_w[4'(lcnt_q - dark_end_w)];
  assign led_d       = lock_disp_w ? led_lock_w : phase_pat(state_q, pidx_q);

  // display cycles repeat endlessly until the state moves on
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      lcnt_q <= 7'h00;
      pidx_q <= 5'h00;
    end else if (chg_w) begin
      lcnt_q <= 7'h00;
      pidx_q <= 5'h00;
    end else if (tick_w) begin
      lcnt_q <= (lcnt_q == cycle_w - 7'h01) ? 7'h00 : lcnt_q + 7'h01;
      pidx_q <= (pidx_q == 5'(burner_pkg::PHASE_FRAME_TK - 1)) ? 5'h00 : pidx_q + 5'h01;
    end
  end

  // actuators from the next state, so outputs change with the state register
  logic fan_d;
  logic ign_d;
  logic v1_d;
  logic v2_d;
  logic alarm_d;
  logic nv_wr_d;

  assign fan_d   = (state_d inside {burner_pkg::ST_QUICK_FAN, burner_pkg::ST_AIR_WAIT,
                    burner_pkg::ST_PREPURGE, burner_pkg::ST_STRAY, burner_pkg::ST_PREIGN,
                    burner_pkg::ST_SAFETY, burner_pkg::ST_POSTIGN, burner_pkg::ST_STAGE2,
                    burner_pkg::ST_RUN});
  assign ign_d   = (state_d inside {burner_pkg::ST_PREIGN, burner_pkg::ST_SAFETY,
                    burner_pkg::ST_POSTIGN});
  assign v1_d    = (state_d inside {burner_pkg::ST_SAFETY, burner_pkg::ST_POSTIGN,
                    burner_pkg::ST_STAGE2, burner_pkg::ST_RUN});
  assign v2_d    = (state_d == burner_pkg::ST_RUN);
  assign alarm_d = (state_d == burner_pkg::ST_LOCKOUT) || (state_d == burner_pkg::ST_QUICK_LOCK);
  assign nv_wr_d = boot_done_w && chg_w &&
                   ((state_d == burner_pkg::ST_LOCKOUT) || (state_q == burner_pkg::ST_LOCKOUT));

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      FAN_MOTOR_O          <= 1'b0;
      IGNITION_O           <= 1'b0;
      FIRST_STAGE_VALVE_O  <= 1'b0;
      SECOND_STAGE_VALVE_O <= 1'b0;
      ALARM_O              <= 1'b0;
      LED_O                <= 1'b0;
      NV_WR_O              <= 1'b0;
      NV_CAUSE_O           <= 3'h0;
    end else begin
      FAN_MOTOR_O          <= fan_d;
      IGNITION_O           <= ign_d;
      FIRST_STAGE_VALVE_O  <= v1_d;
      SECOND_STAGE_VALVE_O <= v2_d;
      ALARM_O              <= alarm_d;
      LED_O                <= led_d;
      NV_WR_O              <= nv_wr_d;
      NV_CAUSE_O           <= cause_d;
    end
  end

  // register port: control written, status read back one cycle later
  logic [7:0] status_w;
  logic [7:0] rmux_w;

  assign status_w = {lock_disp_w, cause_q, state_q};
  assign rmux_w   = (ADDR_I == burner_pkg::REG_CTRL)   ? ctrl_q :
                    (ADDR_I == burner_pkg::REG_STATUS) ? status_w : 8'h00;

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl_q  <= burner_pkg::CTRL_RESET;
      RDATA_O <= 8'h00;
    end else begin
      if (WR_I && (ADDR_I == burner_pkg::REG_CTRL)) begin
        ctrl_q <= WDATA_I & 8'h01;
      end
      RDATA_O <= RD_I ? rmux_w : 8'h00;
    end
  end

endmodule

// file: rtl/pin_sync.sv
// three-stage input synchroniser that accepts a change once stages two and three agree
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // shift chain; s1 feeds s2 only, so no logic sees a metastable level
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // each bit follows only when the last two stages agree
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          q_o[gi] <= 1'b0;
        end else if (s2_q[gi] == s3_q[gi]) begin
          q_o[gi] <= s3_q[gi];
        end
      end
    end
  endgenerate

endmodule

// file: test/burner_field.sv
// field model: air switch and flame detector answering the actuators
module burner_field (
  // actuators and fault modes
  input  wire logic       clk_i,
  input  wire logic       fan_i,
  input  wire logic       valve_i,
  input  wire logic [1:0] air_mode_i,
  input  wire logic [1:0] flame_mode_i,
  // contacts
  output logic            air_o,
  output logic            flame_o
);
  // mode 1 needs airflow or fuel; mode 2 is a welded contact or stray light
  always_ff @(posedge clk_i) begin
    air_o   <= (air_mode_i == 2'h1 && fan_i) || air_mode_i == 2'h2;
    flame_o <= (flame_mode_i == 2'h1 && valve_i) || flame_mode_i == 2'h2;
  end
endmodule

// file: test/burner_sequencer_bench.sv
// self-checking bench for the burner sequencer
module burner_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int V1_TO_V2 = 10 * (burner_pkg::SAFETY_V1_TK + burner_pkg::POSTIGN_V1_TK + burner_pkg::STAGE2_V1_TK);
  logic       clk, rst_n, start, btn, low, wr, rd, air, flame, nv_wr, fan, ign, v1, v2, alarm, led;
  logic [1:0] air_m, flame_m;
  logic [2:0] nv_c, nv_s;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  int         errors, checks_done;
  // short tick keeps every phase between 250 and 6000 cycles
  burner_sequencer #(.TICK_CYC(10), .VARIANT(1'b0)) dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .START_REQ_I(start),
    .AIR_PROVING_CONTACT_I(air), .FLAME_I(flame), .BUTTON_INT_I(1'b0), .BUTTON_EXT_I(btn), .SUPPLY_LOW_I(low),
    .SUPPLY_GOOD_I(!low), .NV_CAUSE_I(nv_s), .NV_WR_O(nv_wr), .NV_CAUSE_O(nv_c), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .FAN_MOTOR_O(fan), .IGNITION_O(ign), .FIRST_STAGE_VALVE_O(v1),
    .SECOND_STAGE_VALVE_O(v2), .ALARM_O(alarm), .LED_O(led));
  burner_field field (.clk_i(clk), .fan_i(fan), .valve_i(v1), .air_mode_i(air_m), .flame_mode_i(flame_m),
    .air_o(air), .flame_o(flame));
  // cause store keeps its word across a reset
  always @(posedge clk) begin
    if (nv_wr) nv_s <= nv_c;
  end
  // clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic report_and_stop;
    if (errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic access(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= w;
    rd    <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    if (!w) check(rdata, d);
  endtask
  // bounded wait, sampled just after each edge
  task automatic wait_hi(ref logic s, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (s !== 1'b1 && n < 20000);
  endtask
  task automatic wait_nv(input logic [2:0] exp);
    int n;
    wait_hi(nv_wr, n);
    check({nv_wr, 4'h0, nv_c}, {1'b1, 4'h0, exp});
    @(posedge clk);
  endtask
  // one tick of slack either side; the prescaler restarts with each phase change
  task automatic wait_v2;
    int n;
    wait_hi(v1, n);
    wait_hi(v2, n);
    check({7'h00, n >= V1_TO_V2 - 10 && n <= V1_TO_V2 + 10}, 8'h01);
    @(posedge clk);
  endtask
  task automatic run_case(input logic [1:0] a, input logic [1:0] f, input logic [1:0] d, input logic [2:0] c);
    @(posedge clk);
    air_m   <= a;
    flame_m <= f;
    if (alarm === 1'b1) begin
      btn <= 1'b1;
      wait_nv(3'h0);
      btn <= 1'b0;
    end
    if (d != 2'h0) begin
      wait_v2;
      if (d == 2'h3) begin
        low <= 1'b1;
        repeat (20) @(posedge clk);
        #1;
        check({5'h00, fan, v1, alarm}, 8'h00);
        @(posedge clk);
        low <= 1'b0;
        wait_v2;
      end
      flame_m <= (d == 2'h2) ? 2'h1 : 2'h0;
      air_m   <= (d == 2'h2) ? 2'h0 : 2'h1;
    end
    wait_nv(c);
    access(1'b0, 4'h1, {1'b1, c, 4'hD});
    check({7'h00, led}, 8'h01);
  endtask
  // main sequence: registers, then one lockout cause per case
  initial begin
    {rst_n, start, btn, low, wr, rd, addr, wdata, nv_s} = '0;
    air_m       = 2'h1;
    flame_m     = 2'h1;
    errors      = 0;
    checks_done = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    access(1'b0, 4'h0, 8'h01);
    access(1'b1, 4'h1, 8'hFF);
    access(1'b0, 4'h1, 8'h00);
    access(1'b0, 4'h7, 8'h00);
    access(1'b1, 4'h0, 8'hFF);
    access(1'b0, 4'h0, 8'h01);
    @(posedge clk);
    start <= 1'b1;
    run_case(2'h1, 2'h1, 2'h1, 3'h6);
    run_case(2'h1, 2'h1, 2'h2, 3'h5);
    run_case(2'h1, 2'h1, 2'h3, 3'h6);
    run_case(2'h1, 2'h2, 2'h0, 3'h2);
    run_case(2'h1, 2'h0, 2'h0, 3'h1);
    run_case(2'h0, 2'h0, 2'h0, 3'h4);
    run_case(2'h2, 2'h0, 2'h0, 3'h3);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    access(1'b0, 4'h1, 8'hBD);
    repeat (1020) @(posedge clk);
    check({7'h00, led}, 8'h00);
    report_and_stop;
  end
  // watchdog well past the expected run of about 35000 cycles
  initial begin
    repeat (80000) @(posedge clk);
    errors++;
    report_and_stop;
  end
endmodule

// file: test/burner_sequencer_properties.sv
// port assertions for the burner sequencer
module burner_sequencer_properties (
  // watched ports
  input wire logic       SYS_CLK_I,
  input wire logic       RST_N_I,
  input wire logic       RD_I,
  input wire logic       SUPPLY_LOW_I,
  input wire logic [7:0] RDATA_O,
  input wire logic       NV_WR_O,
  input wire logic [2:0] NV_CAUSE_O,
  input wire logic       FAN_MOTOR_O,
  input wire logic       IGNITION_O,
  input wire logic       FIRST_STAGE_VALVE_O,
  input wire logic       SECOND_STAGE_VALVE_O,
  input wire logic       ALARM_O,
  input wire logic       LED_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // lockout entry, then the steady part of the display
  sequence lock_entry; $rose(ALARM_O); endsequence
  sequence led_held; LED_O [*8]; endsequence
  a_lockout_all_off: assert property (ALARM_O |-> !(FAN_MOTOR_O | IGNITION_O |
    FIRST_STAGE_VALVE_O | SECOND_STAGE_VALVE_O)) else $error("actuator on while alarm raised");
  a_lockout_led_lit: assert property (lock_entry |-> ##[0:1] led_held) else $error("led not steady in lockout");
  a_stage_two_order: assert property (SECOND_STAGE_VALVE_O |-> FIRST_STAGE_VALVE_O)
    else $error("stage two alone");
  a_fuel_needs_fan: assert property (FIRST_STAGE_VALVE_O || IGNITION_O |-> FAN_MOTOR_O)
    else $error("fuel without fan");
  a_nv_write_pulse: assert property (NV_WR_O |=> !NV_WR_O) else $error("store write longer than one cycle");
  a_nv_cause_lock: assert property (NV_WR_O && NV_CAUSE_O != 3'h0 |-> ##[0:2] ALARM_O)
    else $error("cause stored, no lockout");
  a_rdata_quiet: assert property (!RD_I |=> RDATA_O == 8'h00) else $error("read data without read");
  // sync latency plus the output register fit in eight cycles
  a_undervolt_off: assert property (SUPPLY_LOW_I [*8] |-> !(FAN_MOTOR_O | IGNITION_O | FIRST_STAGE_VALVE_O))
    else $error("burner on at low supply");
endmodule
bind burner_sequencer burner_sequencer_properties chk (.SYS_CLK_I, .RST_N_I, .RD_I, .SUPPLY_LOW_I, .RDATA_O, .NV_WR_O,
  .NV_CAUSE_O, .FAN_MOTOR_O, .IGNITION_O, .FIRST_STAGE_VALVE_O, .SECOND_STAGE_VALVE_O, .ALARM_O, .LED_O);
